// *** rtl/touch_filter_pkg.sv ***
// shared constants for the touch adc result filter
package touch_filter_pkg;

  // clock and timing
  localparam int unsigned CLK_MHZ        = 10;          // mclk rate in MHz
  localparam int unsigned ACQ_BASE_US    = 2;           // shortest programmable acquisition
  localparam int unsigned ACQ_BASE_CYC   = ACQ_BASE_US * CLK_MHZ;
  localparam int unsigned SORT_NS        = 2000;        // time to rank one sample
  localparam int unsigned SORT_CYC       = (SORT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned TEMP_ACQ_MS    = 16;          // fixed temperature acquisition
  localparam int unsigned TEMP_ACQ_CYC   = TEMP_ACQ_MS * 1000 * 1000 * CLK_MHZ / 1000;

  // register offsets
  localparam logic [7:0]  ADDR_CTRL_ONE  = 8'h01;
  localparam logic [7:0]  ADDR_CTRL_TWO  = 8'h02;
  localparam logic [7:0]  ADDR_TEMP_HI   = 8'h06;
  localparam logic [7:0]  ADDR_TEMP_LO   = 8'h07;
  localparam logic [7:0]  ADDR_PRESS_ONE = 8'h0A;
  localparam logic [7:0]  ADDR_PRESS_TWO = 8'h0B;
  localparam logic [7:0]  ADDR_AUX_BAT   = 8'h0C;
  localparam logic [7:0]  ADDR_TEMP_RES  = 8'h0D;

  // reset values
  localparam logic [15:0] RST_CTRL_ONE   = 16'h0000;
  localparam logic [15:0] RST_CTRL_TWO   = 16'h4040;
  localparam logic [15:0] RST_LIMIT      = 16'h0000;

  // field positions
  localparam int unsigned CH_LSB         = 12;          // channel code, 3 bits, ctrl one
  localparam int unsigned ACQ_LSB        = 8;           // acquisition select, 2 bits, ctrl one
  localparam int unsigned MED_LSB        = 5;           // rank size, 2 bits, ctrl two
  localparam int unsigned AVG_LSB        = 7;           // mean size, 2 bits, ctrl two
  localparam int unsigned GPIO_EN_BIT    = 13;          // pin mode, ctrl two

  // channel codes
  localparam logic [2:0]  CH_TEMP        = 3'h1;
  localparam logic [2:0]  CH_BATTERY     = 3'h2;
  localparam logic [2:0]  CH_AUX         = 3'h3;
  localparam logic [2:0]  CH_PRESS_TWO   = 3'h4;
  localparam logic [2:0]  CH_PRESS_ONE   = 3'h5;

  localparam int unsigned RANK_DEPTH     = 16;          // deepest rank array

endpackage

// *** rtl/rank_store.sv ***
// sample array that keeps entries ordered smallest first, or in arrival order
`timescale 1ns/1ps
`default_nettype none
module rank_store
  import touch_filter_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        clear,      // empty the array
  input  wire logic        push,       // one new sample
  input  wire logic        sorted,     // insert in rank order, else append
  input  wire logic [11:0] din,
  input  wire logic [3:0]  rd_idx,
  output logic      [11:0] rd_data
);

  logic [11:0] arr [RANK_DEPTH];       // samples, index 0 smallest when sorted
  logic [4:0]  count;                  // valid entries
  logic [4:0]  pos;                    // insertion slot

  // slot = number of stored entries not above the new one
  always_comb begin
    pos = count;
    if (sorted) begin
      pos = 5'h00;
      for (int i = 0; i < RANK_DEPTH; i++) begin
        if ((5'(i) < count) && (arr[i] <= din)) begin
          pos = pos + 5'h01;
        end
      end
    end
  end

  assign rd_data = arr[rd_idx];

  // insertion shifts larger entries one place up
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      count <= 5'h00;
      for (int i = 0; i < RANK_DEPTH; i++) begin
        arr[i] <= 12'h000;
      end
    end else if (clear) begin
      count <= 5'h00;
    end else if (push && (count < 5'(RANK_DEPTH))) begin
      count <= count + 5'h01;
      for (int i = 0; i < RANK_DEPTH; i++) begin
        if (5'(i) == pos) begin
          arr[i] <= din;
        end else if ((5'(i) > pos) && (i > 0)) begin
          arr[i] <= arr[(i > 0) ? i - 1 : 0];
        end
      end
    end
  end

endmodule
`default_nettype wire

// *** rtl/touch_adc_result_filter.sv ***
// conversion run control, rank and mean filtering, result registers
// What this block does
// - code 001 stores one temperature result
// - temperature uses fixed acquisition, ignores setting
// - temperature limits compare raw result register
// - rank size field picks 0/4/8/16 samples
// - rank array ordered smallest first
// - mean size field picks 2/4/8/16 middle
// - only final mean reaches result register
// - both fields zero: one unfiltered sample
// - equal counts: no ranking, plain mean
// - rank larger: mean of middle entries
// - ranking adds sort time per sample
// - code 011 routes auxiliary, shared result
// - code 010 selects battery, shared result
// - ctrl two bit 13 sets pin mode
// - battery divider on only while sampling battery
// - codes 101/100 store pressure results
// - same rank and sort time as other codes
`timescale 1ns/1ps
`default_nettype none
module touch_adc_result_filter
  import touch_filter_pkg::*;
#(
  parameter int unsigned TEMP_ACQ_CYCLES = TEMP_ACQ_CYC  // shorten in simulation
)(
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  reg_addr,       // register index
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,         // one-cycle write strobe
  input  wire logic        reg_rd,         // one-cycle read strobe
  output logic      [15:0] reg_rdata,      // valid the cycle after reg_rd
  output logic             adc_sample,     // analog input held in acquisition
  output logic             adc_start,      // one-cycle conversion start
  output logic      [2:0]  adc_channel,    // mux code of the running run
  input  wire logic        adc_done,       // conversion finished, data valid
  input  wire logic [11:0] adc_data,
  output logic             battery_div_en, // battery divider power
  output logic             pin_gpio_mode,  // multifunction pin in digital mode
  output logic             temp_over,      // last temperature above high limit
  output logic             temp_under,     // last temperature below low limit
  output logic             busy
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  typedef enum logic [2:0] {IDLE, ACQ, CONV, SORT, NEXT, AVG, WRITE} run_state_e;

  logic [15:0] conversion_control_one;   // channel and acquisition
  logic [15:0] conversion_control_two;   // filter sizes and pin mode
  logic [15:0] temp_high_limit;
  logic [15:0] temp_low_limit;
  logic [11:0] pressure_meas_first;
  logic [11:0] pressure_meas_second;
  logic [11:0] aux_battery_result;
  logic [11:0] temperature_result;

  run_state_e  state;
  run_state_e  next_state;
  logic [17:0] cnt;                      // acquisition and sort timer
  logic [17:0] acq_len;                  // acquisition cycles of this run
  logic [4:0]  n_samp;                   // samples to take
  logic [4:0]  a_cnt;                    // samples to average
  logic [2:0]  shift;                    // log2 of a_cnt
  logic        sorted;                   // rank the samples
  logic [4:0]  taken;                    // samples already converted
  logic [3:0]  idx;                      // array read pointer
  logic [4:0]  summed;                   // entries already summed
  logic [15:0] sum;                      // 16 x 4095 fits
  logic [11:0] rd_data;
  logic        start_req;                // write to ctrl one starts a run when idle
  logic [1:0]  med_sel;                  // rank size field as set now
  logic [1:0]  avg_sel;                  // mean size field as set now
  logic [4:0]  rank_n;                   // rank sample count
  logic [4:0]  mean_n;                   // mean sample count
  logic [2:0]  run_code;                 // channel code a new run will use
  logic [11:0] mean_val;                 // final scaled mean

  assign start_req = reg_wr && (reg_addr == ADDR_CTRL_ONE);

  // field decode; shift amounts are 3-bit so a count of 16 cannot wrap to 1
  assign med_sel  = conversion_control_two[MED_LSB +: 2];
  assign avg_sel  = conversion_control_two[AVG_LSB +: 2];
  assign rank_n   = 5'h01 << (3'(med_sel) + 3'h1);
  assign mean_n   = 5'h01 << (3'(avg_sel) + 3'h1);
  assign run_code = reg_wdata[CH_LSB +: 3];
  assign mean_val = 12'(sum >> shift);

  // software writes; results are read only
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      conversion_control_one <= RST_CTRL_ONE;
      conversion_control_two <= RST_CTRL_TWO;
      temp_high_limit        <= RST_LIMIT;
      temp_low_limit         <= RST_LIMIT;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_CTRL_ONE: conversion_control_one <= reg_wdata;
        ADDR_CTRL_TWO: conversion_control_two <= reg_wdata;
        ADDR_TEMP_HI:  temp_high_limit        <= reg_wdata;
        ADDR_TEMP_LO:  temp_low_limit         <= reg_wdata;
        default: begin
          // unmapped or read-only: ignored
        end
      endcase
    end
  end

  // registered read, unmapped reads zero
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL_ONE:  reg_rdata <= conversion_control_one;
        ADDR_CTRL_TWO:  reg_rdata <= conversion_control_two;
        ADDR_TEMP_HI:   reg_rdata <= temp_high_limit;
        ADDR_TEMP_LO:   reg_rdata <= temp_low_limit;
        ADDR_PRESS_ONE: reg_rdata <= {4'h0, pressure_meas_first};
        ADDR_PRESS_TWO: reg_rdata <= {4'h0, pressure_meas_second};
        ADDR_AUX_BAT:   reg_rdata <= {4'h0, aux_battery_result};
        ADDR_TEMP_RES:  reg_rdata <= {4'h0, temperature_result};
        default:        reg_rdata <= 16'h0000;
      endcase
    end
  end

  // pin mode follows the enable bit, registered one cycle later
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pin_gpio_mode <= 1'b0;
    end else begin
      pin_gpio_mode <= conversion_control_two[GPIO_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // run sequencing

  // next state from counters and converter handshake
  always_comb begin
    next_state = state;
    case (state)
      IDLE: begin
        if (start_req) begin
          next_state = ACQ;
        end
      end
      ACQ: begin
        if (cnt == acq_len - 18'h00001) begin
          next_state = CONV;
        end
      end
      CONV: begin
        if (adc_done) begin
          next_state = sorted ? SORT : NEXT;
        end
      end
      SORT: begin
        if (cnt == 18'(SORT_CYC - 1)) begin
          next_state = NEXT;
        end
      end
      NEXT: begin
        next_state = (taken == n_samp) ? AVG : ACQ;
      end
      AVG: begin
        if (summed == a_cnt) begin
          next_state = WRITE;
        end
      end
      WRITE:   next_state = IDLE;
      default: next_state = IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= IDLE;
    end else begin
      state <= next_state;
    end
  end

  // latch run configuration at the start
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      acq_len     <= 18'h00001;
      n_samp      <= 5'h01;
      a_cnt       <= 5'h01;
      shift       <= 3'h0;
      sorted      <= 1'b0;
      adc_channel <= 3'h0;
    end else if ((state == IDLE) && start_req) begin
      adc_channel <= run_code;
      if (run_code == CH_TEMP) begin
        acq_len <= 18'(TEMP_ACQ_CYCLES);
      end else begin
        acq_len <= 18'(ACQ_BASE_CYC) << reg_wdata[ACQ_LSB +: 2];
      end
      if ((med_sel == 2'h0) && (avg_sel == 2'h0)) begin
        n_samp <= 5'h01;
        a_cnt  <= 5'h01;
        shift  <= 3'h0;
        sorted <= 1'b0;
      end else if ((med_sel == 2'h0) || (rank_n <= mean_n)) begin
        // no rank stage: smaller rank count is unsupported, mean alone
        n_samp <= mean_n;
        a_cnt  <= mean_n;
        shift  <= 3'(avg_sel) + 3'h1;
        sorted <= 1'b0;
      end else begin
        n_samp <= rank_n;
        a_cnt  <= mean_n;
        shift  <= 3'(avg_sel) + 3'h1;
        sorted <= 1'b1;
      end
    end
  end

  // acquisition and sort timer
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 18'h00000;
    end else if (next_state != state) begin
      cnt <= 18'h00000;
    end else if ((state == ACQ) || (state == SORT)) begin
      cnt <= cnt + 18'h00001;
    end
  end

  // samples taken and averaging pointer
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      taken  <= 5'h00;
      idx    <= 4'h0;
      summed <= 5'h00;
      sum    <= 16'h0000;
    end else begin
      case (state)
        IDLE: begin
          taken  <= 5'h00;
          summed <= 5'h00;
          sum    <= 16'h0000;
        end
        CONV: begin
          if (adc_done) begin
            taken <= taken + 5'h01;
          end
          // start of the middle window, (n - a) / 2
          idx <= 4'((n_samp - a_cnt) >> 1);
        end
        AVG: begin
          if (summed != a_cnt) begin
            sum    <= sum + {4'h0, rd_data};
            idx    <= idx + 4'h1;
            summed <= summed + 5'h01;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // sample array, ranked only when the rank stage is active
  rank_store u_rank (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .clear   (state == IDLE),
    .push    ((state == CONV) && adc_done),
    .sorted  (sorted),
    .din     (adc_data),
    .rd_idx  (idx),
    .rd_data (rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // results

  // only the final mean is stored, by channel code
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pressure_meas_first  <= 12'h000;
      pressure_meas_second <= 12'h000;
      aux_battery_result   <= 12'h000;
      temperature_result   <= 12'h000;
      temp_over            <= 1'b0;
      temp_under           <= 1'b0;
    end else if (state == WRITE) begin
      case (adc_channel)
        CH_TEMP: begin
          temperature_result <= mean_val;
          // raw code against raw limits, no scaling
          temp_over  <= {4'h0, mean_val} > temp_high_limit;
          temp_under <= {4'h0, mean_val} < temp_low_limit;
        end
        CH_BATTERY:   aux_battery_result   <= mean_val;
        CH_AUX:       aux_battery_result   <= mean_val;
        CH_PRESS_ONE: pressure_meas_first  <= mean_val;
        CH_PRESS_TWO: pressure_meas_second <= mean_val;
        default: begin
          // position codes have no result register in this block
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // converter strobes, all registered from the coming state

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      adc_sample     <= 1'b0;
      adc_start      <= 1'b0;
      battery_div_en <= 1'b0;
      busy           <= 1'b0;
    end else begin
      adc_sample     <= (next_state == ACQ);
      adc_start      <= (state == ACQ) && (next_state == CONV);
      // divider draws current, so power it only while sampling
      battery_div_en <= (next_state == ACQ)
                        && (((state == IDLE) ? run_code : adc_channel) == CH_BATTERY);
      busy           <= (next_state != IDLE);
    end
  end

endmodule
`default_nettype wire

// *** test/touch_filter_props.sv ***
// port checker for the result filter
`timescale 1ns/1ps
`default_nettype none
module touch_filter_props
  import touch_filter_pkg::*;
#(
  parameter int unsigned TEMP_ACQ_CYCLES = TEMP_ACQ_CYC
)(
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        adc_sample,
  input wire logic        adc_start,
  input wire logic [2:0]  adc_channel,
  input wire logic        adc_done,
  input wire logic [11:0] adc_data,
  input wire logic        battery_div_en,
  input wire logic        pin_gpio_mode,
  input wire logic        temp_over,
  input wire logic        temp_under,
  input wire logic        busy
);
  logic [17:0] acq_cnt; // cycles of this acquisition
  logic        rank_on; // rank count above mean count
  logic        mapped;  // index with a register
  assign mapped = reg_addr inside {ADDR_CTRL_ONE, ADDR_CTRL_TWO, ADDR_TEMP_HI,
    ADDR_TEMP_LO, ADDR_PRESS_ONE, ADDR_PRESS_TWO, ADDR_AUX_BAT, ADDR_TEMP_RES};
  ////////////////////////////////////////////////////////////
  // count acquisition length, zero outside
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n)
      acq_cnt <= 18'h00000;
    else if (adc_sample)
      acq_cnt <= acq_cnt + 18'h00001;
    else
      acq_cnt <= 18'h00000;
  end
  // mirror of rank mode; reset sizes are rank 8, mean 2
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n)
      rank_on <= 1'b1;
    else if (reg_wr && reg_addr == ADDR_CTRL_TWO)
      rank_on <= reg_wdata[MED_LSB+:2] > reg_wdata[AVG_LSB+:2];
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_start_after_acq: assert property ($fell(adc_sample) |-> adc_start)
    else $error("no start after acquisition");
  a_start_one_pulse: assert property (adc_start |=> !adc_start)
    else $error("start longer than one cycle");
  a_temp_acq_fixed: assert property ($fell(adc_sample) && adc_channel == CH_TEMP
    |-> acq_cnt == TEMP_ACQ_CYCLES) else $error("temperature acquisition length wrong");
  a_acq_len_legal: assert property ($fell(adc_sample) && adc_channel != CH_TEMP
    |-> acq_cnt inside {20, 40, 80, 160}) else $error("acquisition length wrong");
  a_divider_only_bat: assert property (battery_div_en |-> adc_channel == CH_BATTERY
    && adc_sample) else $error("divider on outside battery sample");
  a_divider_on_bat: assert property (adc_sample
    && adc_channel == CH_BATTERY |-> battery_div_en) else $error("divider off in sample");
  a_pin_mode_follow: assert property (reg_wr && reg_addr == ADDR_CTRL_TWO
    |-> ##2 pin_gpio_mode == $past(reg_wdata[GPIO_EN_BIT], 2)) else $error("pin mode wrong");
  a_result_upper_zero: assert property (reg_rd && reg_addr >= ADDR_PRESS_ONE
    && reg_addr <= ADDR_TEMP_RES |=> reg_rdata[15:12] == 4'h0) else $error("upper bits set");
  a_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
  a_sort_gap: assert property (adc_done && rank_on |=> !adc_sample [*8])
    else $error("no sort time after sample");
endmodule
bind touch_adc_result_filter touch_filter_props #(.TEMP_ACQ_CYCLES(TEMP_ACQ_CYCLES))
  u_touch_filter_props (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .adc_sample(adc_sample), .adc_start(adc_start), .adc_channel(adc_channel),
  .adc_done(adc_done), .adc_data(adc_data), .battery_div_en(battery_div_en),
  .pin_gpio_mode(pin_gpio_mode), .temp_over(temp_over), .temp_under(temp_under),
  .busy(busy));
`default_nettype wire

// *** test/adc_model.sv ***
// converter model: answers each start after a set latency
`timescale 1ns/1ps
`default_nettype none
module adc_model (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        adc_start,
  input  wire logic        rewind,   // restart the value list
  input  wire logic [3:0]  lat,      // start to done, 1 or more
  output logic             adc_done,
  output logic      [11:0] adc_data
);
  logic [11:0] vals [0:15]; // values in turn, loaded by the bench
  logic [3:0]  idx;
  logic [3:0]  wait_cnt;
  // data line toggles outside done so stale data never looks valid
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      adc_done <= 1'b0;
      adc_data <= 12'hA5A;
      idx <= 4'h0;
      wait_cnt <= 4'h0;
    end else begin
      adc_done <= 1'b0;
      adc_data <= ~adc_data;
      if (rewind)
        idx <= 4'h0;
      if (adc_start) begin
        wait_cnt <= lat;
      end else if (wait_cnt == 4'h1) begin
        adc_done <= 1'b1;
        adc_data <= vals[idx];
        idx <= idx + 4'h1;
        wait_cnt <= 4'h0;
      end else if (wait_cnt > 4'h1)
        wait_cnt <= wait_cnt - 4'h1;
    end
  end
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// self-checking bench of the result filter
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import touch_filter_pkg::*;
;
  logic        mclk, arst_n, reg_wr, reg_rd, adc_sample, adc_start, adc_done;
  logic        battery_div_en, pin_gpio_mode, temp_over, temp_under, busy, rewind;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [2:0]  adc_channel;
  logic [11:0] adc_data;
  logic [3:0]  lat;         // converter answer delay
  logic        rd_seen;     // read taken last edge
  logic [15:0] exp_q [$];   // expected read data
  int          tv [0:2] = '{32'h0F00, 32'h0050, 32'h0400}; // raw temperatures
  int          failures;
  int          checked;
  touch_adc_result_filter #(.TEMP_ACQ_CYCLES(50)) u_touch_adc_result_filter (
    .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_sample(adc_sample),
    .adc_start(adc_start), .adc_channel(adc_channel), .adc_done(adc_done),
    .adc_data(adc_data), .battery_div_en(battery_div_en), .pin_gpio_mode(pin_gpio_mode),
    .temp_over(temp_over), .temp_under(temp_under), .busy(busy));
  adc_model u_adc_model (.mclk(mclk), .arst_n(arst_n), .adc_start(adc_start),
    .rewind(rewind), .lat(lat), .adc_done(adc_done), .adc_data(adc_data));
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("counts: checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // register write and read, one strobe cycle each
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    exp_q.push_back(e);
    @(negedge mclk);
    reg_rd = 1'b0;
  endtask
  // bounded wait for the run to end
  task automatic wait_idle();
    int n = 0;
    repeat (3) @(negedge mclk);
    while (busy !== 1'b0 && n < 20000) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 20000) begin
      failures++;
      $display("[FAIL] %0t run never finished", $time);
      close_out();
    end
  endtask
  // one filtered run; mean worked out here from the samples
  task automatic run(input logic [1:0] med, input logic [1:0] avg, input logic [2:0] ch,
                     input logic [7:0] res, input logic [1:0] acq, input logic gpio,
                     input int fixv);
    logic [11:0] s [$];
    logic [15:0] sum;
    logic [11:0] expv;
    int m, a, n, first;
    m = (med == 2'h0) ? 0 : 2 << med;
    a = 2 << avg;
    n = (med == 2'h0 && avg == 2'h0) ? 1 : ((m <= a) ? a : m);
    for (int i = 0; i < n; i++) begin
      s.push_back((fixv < 0) ? 12'($urandom_range(0, 4095)) : 12'(fixv));
      u_adc_model.vals[i] = s[i];
    end
    @(negedge mclk);
    rewind = 1'b1;
    lat = 4'($urandom_range(1, 6));
    @(negedge mclk);
    rewind = 1'b0;
    wr(ADDR_CTRL_TWO, {2'h0, gpio, 4'h0, avg, med, 5'h00});
    wr(ADDR_CTRL_ONE, {1'b0, ch, 2'h0, acq, 8'h00});
    wait_idle();
    if (m > a)
      s.sort();
    first = (m > a) ? (m - a) / 2 : 0;
    sum = 16'h0000;
    for (int i = 0; i < ((n == 1) ? 1 : a); i++)
      sum += 16'(s[first + i]);
    expv = (n == 1) ? s[0] : 12'(sum >> (int'(avg) + 1));
    rd(res, {4'h0, expv});
    check({15'h0000, pin_gpio_mode}, {15'h0000, gpio});
  endtask
  ////////////////////////////////////////////////////////////
  // read taken, then the oldest note is compared
  always @(posedge mclk) rd_seen <= reg_rd;
  always @(negedge mclk) begin
    if (rd_seen === 1'b1 && exp_q.size() > 0)
      check(reg_rdata, exp_q.pop_front());
  end
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    failures = 0;
    checked = 0;
    arst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rewind = 1'b0;
    lat = 4'h1;
    void'($urandom(87856));
    repeat (2) @(negedge mclk);
    arst_n = 1'b1;
    rd(ADDR_CTRL_ONE, 16'h0000);
    rd(ADDR_CTRL_TWO, 16'h4040);
    rd(ADDR_AUX_BAT, 16'h0000);
    wr(ADDR_TEMP_RES, 16'hFFFF);
    rd(ADDR_TEMP_RES, 16'h0000);
    wr(8'h0F, 16'hFFFF);
    rd(8'h0F, 16'h0000);
    $display("test registers done");
    // rank count kept at or above mean count, or rank stage off
    run(2'h0, 2'h0, CH_PRESS_ONE, ADDR_PRESS_ONE, 2'h0, 1'b0, -1);
    run(2'h1, 2'h0, CH_PRESS_TWO, ADDR_PRESS_TWO, 2'h1, 1'b1, -1);
    run(2'h3, 2'h2, CH_AUX, ADDR_AUX_BAT, 2'h2, 1'b0, -1);
    run(2'h2, 2'h2, CH_BATTERY, ADDR_AUX_BAT, 2'h3, 1'b1, -1);
    run(2'h3, 2'h3, CH_PRESS_ONE, ADDR_PRESS_ONE, 2'h0, 1'b0, -1);
    run(2'h0, 2'h1, CH_AUX, ADDR_AUX_BAT, 2'h1, 1'b0, -1);
    run(2'h2, 2'h0, CH_BATTERY, ADDR_AUX_BAT, 2'h0, 1'b0, -1);
    $display("test filters done");
    wr(ADDR_TEMP_HI, 16'h0800);
    wr(ADDR_TEMP_LO, 16'h0100);
    foreach (tv[i]) begin
      run(2'h0, 2'h0, CH_TEMP, ADDR_TEMP_RES, 2'(i), 1'b0, tv[i]);
      check({15'h0000, temp_over}, {15'h0000, tv[i] > 32'h0800});
      check({15'h0000, temp_under}, {15'h0000, tv[i] < 32'h0100});
    end
    $display("test temperature done");
    // reset in mid run
    wr(ADDR_CTRL_ONE, {1'b0, CH_AUX, 12'h000});
    repeat (5) @(negedge mclk);
    arst_n = 1'b0;
    @(negedge mclk);
    arst_n = 1'b1;
    check({15'h0000, busy}, 16'h0000);
    rd(ADDR_CTRL_TWO, 16'h4040);
    $display("test reset done");
    close_out();
  end
endmodule
`default_nettype wire
